// ===== inc/cic_defines.vh
// Constants for the interrupt controller: addresses, bit fields, resets, timing
`ifndef CIC_DEFINES_VH
`define CIC_DEFINES_VH

// Special-function-register addresses
`define CIC_ADDR_EN 8'hA8
`define CIC_ADDR_PRIO 8'hB8
`define CIC_ADDR_EIE_A 8'hE6
`define CIC_ADDR_EIE_B 8'hE7
`define CIC_ADDR_EIP_A 8'hF6
`define CIC_ADDR_EIP_B 8'hF7
`define CIC_ADDR_TCTL 8'h88

// Reset values
`define CIC_RST_EN 8'h00
`define CIC_RST_PRIO 8'h00
`define CIC_RST_EXT 8'h00
`define CIC_RST_TCTL 4'h0

// Read-back shaping: unused bits of the base priority register read one,
// unused bits of the second extended registers read zero
`define CIC_PRIO_READ_ONES 8'hC0
`define CIC_EXT_B_MASK 8'h5F

// Enable register fields
`define CIC_EN_GATE_BIT 7
`define CIC_EN_SPARE_BIT 6

// Timer control fields: sense select at 2k, pending flag at 2k+1
`define CIC_TCTL_WIDTH 4

// Source slots
`define CIC_NUM_SLOTS 21
`define CIC_SLOT_W 5
`define CIC_SLOT_EXT0 5'h00
`define CIC_SLOT_EXT1 5'h02

// Vector generation: base plus eight times the slot
`define CIC_VEC_BASE 16'h0003
`define CIC_VEC_PAD 8'h00

// Timing in system clocks
`define CIC_DETECT_CYCLES 1
`define CIC_CALL_CYCLES 4
`define CIC_CNT_W 3

`endif

// ===== hw/cic_arbiter.v
// Fixed-order two-level arbiter: high level first, then lowest slot
module cic_arbiter #(
  parameter N = 21,
  parameter SW = 5
) (
  // Requests and their levels
  input wire [N-1:0] req,
  input wire [N-1:0] prio,
  // Winner
  output reg found,
  output reg [SW-1:0] slot,
  output reg level
);

  reg [N-1:0] sel;
  integer i;

  // Scan downward so the lowest set slot is the last to overwrite
  always @* begin
    level = |(req & prio);
    found = |req;
    sel = level ? (req & prio) : req;
    slot = {SW{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (sel[i]) begin
        slot = i[SW-1:0];
      end
    end
  end

endmodule

// ===== hw/cic_top.v
// Interrupt controller top: SFRs, external inputs, arbitration, call sequence
//
// What this block does
// - Twenty sources, each with pending flag and vector
// - Software-set external pending flag acts like hardware event in edge mode only; level mode ignores the write
// - External inputs active low, sense bits 0/2
// - External pending flags are timer control bits 1/3
// - Edge mode: falling edge sets, vectoring clears
// - Level mode: flag follows inverted pin directly
// - External zero vectors 0x0003, order position 0
// - Comparator-one rising: 0x006B, position 13, bit 7
// - ADC0 done: 0x007B, position 15, bit 1
// - ADC2 done: 0x0093, position 18, bit 4
// - High preempts low; nothing preempts high
// - All priority bits reset to low
// - High first, then lowest order position wins
// - Requests sampled and decoded every clock
// - Five clocks minimum: detect one, call four
// - After return, one instruction before next call
// - Equal or lower waits for return plus one
// - Global gate bit 7 overrides all masks
// - Enable bit 6 is a plain software flag
// - Enable bits 5..0 mask six base sources
// - Enable register at 0xA8, resets to zero
// - Flags set regardless of enable; call after instruction
// - Flag still set after return re-requests immediately
// - Priority bit one means high, zero low
`include "cic_defines.vh"

module cic_top #(
  parameter NUM_SLOTS = `CIC_NUM_SLOTS,
  parameter SLOT_W = `CIC_SLOT_W
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Special-function-register port from the core
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  // External interrupt pins, active low
  input wire external_irq_zero_pin_n,
  input wire external_irq_one_pin_n,
  // Pending flags of on-chip peripherals, one per slot
  input wire [NUM_SLOTS-1:0] src_pending,
  // Core sequencer handshake
  input wire cpu_boundary,
  input wire cpu_reti,
  // Call sequence towards the core
  output reg lcall_active,
  output reg [15:0] irq_vector,
  output reg isr_enter,
  output reg [SLOT_W-1:0] isr_slot,
  // In-service levels: bit 1 high, bit 0 low
  output reg [1:0] in_service
);

  localparam ST_IDLE = 1'b0;
  localparam ST_CALL = 1'b1;
  localparam integer CALL_LAST_I = `CIC_CALL_CYCLES - 1;
  localparam [`CIC_CNT_W-1:0] CALL_LAST = CALL_LAST_I[`CIC_CNT_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg [7:0] interrupt_enable_register;
  reg [7:0] base_priority_reg;
  reg [7:0] ext_enable_reg_a;
  reg [7:0] ext_enable_reg_b;
  reg [7:0] ext_priority_reg_a;
  reg [7:0] ext_priority_reg_b;
  reg [1:0] edge_select;
  wire [1:0] ext_pending;
  wire [1:0] ext_pin_n;
  wire [1:0] ext_clear;
  wire tctl_wr;

  // Sequencer state
  reg state;
  reg [`CIC_CNT_W-1:0] call_cnt;
  reg call_level;
  reg reti_hold;
  reg win_found;
  reg [SLOT_W-1:0] win_slot;
  reg win_level;

  // Arbiter results
  wire arb_found;
  wire [SLOT_W-1:0] arb_slot;
  wire arb_level;

  wire global_irq_gate;
  wire [NUM_SLOTS-1:0] pend_all;
  wire [NUM_SLOTS-1:0] mask_all;
  wire [NUM_SLOTS-1:0] prio_all;
  wire [NUM_SLOTS-1:0] req_all;
  wire eligible;
  wire take;
  wire [15:0] next_vector;

  // Vector address for a slot: base plus eight times the slot
  function [15:0] slot_vector;
    input [SLOT_W-1:0] s;
    begin
      slot_vector = `CIC_VEC_BASE + {`CIC_VEC_PAD, s, 3'h0};
    end
  endfunction

  assign ext_pin_n = {external_irq_one_pin_n, external_irq_zero_pin_n};
  assign tctl_wr = sfr_wr && (sfr_addr == `CIC_ADDR_TCTL);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  // Byte writes; bit-addressed updates arrive as read-modify-write bytes
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      interrupt_enable_register <= `CIC_RST_EN;
      base_priority_reg <= `CIC_RST_PRIO;
      ext_enable_reg_a <= `CIC_RST_EXT;
      ext_enable_reg_b <= `CIC_RST_EXT;
      ext_priority_reg_a <= `CIC_RST_EXT;
      ext_priority_reg_b <= `CIC_RST_EXT;
      edge_select <= 2'h0;
    end else if (sfr_wr) begin
      case (sfr_addr)
        `CIC_ADDR_EN: interrupt_enable_register <= sfr_wdata;
        `CIC_ADDR_PRIO: base_priority_reg <= sfr_wdata & ~`CIC_PRIO_READ_ONES;
        `CIC_ADDR_EIE_A: ext_enable_reg_a <= sfr_wdata;
        `CIC_ADDR_EIE_B: ext_enable_reg_b <= sfr_wdata & `CIC_EXT_B_MASK;
        `CIC_ADDR_EIP_A: ext_priority_reg_a <= sfr_wdata;
        `CIC_ADDR_EIP_B: ext_priority_reg_b <= sfr_wdata & `CIC_EXT_B_MASK;
        `CIC_ADDR_TCTL: edge_select <= {sfr_wdata[2], sfr_wdata[0]};
        default: edge_select <= edge_select;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External inputs

  // Same detector for both pins; sense select at 2k, flag at 2k+1
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_ext
      localparam integer MY_SLOT_I = 2 * k;
      localparam [SLOT_W-1:0] MY_SLOT = MY_SLOT_I[SLOT_W-1:0];
      reg pin_prev;
      reg flag;
      wire fall;
      // Pins are synchronous to clk, so one history bit suffices
      assign fall = pin_prev && !ext_pin_n[k];
      assign ext_clear[k] = isr_enter && (isr_slot == MY_SLOT);
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pin_prev <= 1'b1;
          flag <= 1'b0;
        end else begin
          pin_prev <= ext_pin_n[k];
          if (!edge_select[k]) begin
            // Level sense: no latching, a released pin drops the flag
            flag <= !ext_pin_n[k];
          end else if (fall) begin
            // Edge wins over a clear in the same cycle
            flag <= 1'b1;
          end else if (tctl_wr) begin
            flag <= sfr_wdata[2*k+1];
          end else if (ext_clear[k]) begin
            flag <= 1'b0;
          end
        end
      end
      assign ext_pending[k] = flag;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Request formation

  // Slot 19 has no source and is tied off; externals replace slots 0 and 2
  assign pend_all = {src_pending[20], 1'b0, src_pending[18:3],
                     ext_pending[1], src_pending[1], ext_pending[0]};
  // Mask per slot: base enables 5..0, then both extended registers
  assign mask_all = {ext_enable_reg_b[6:0], ext_enable_reg_a,
                     interrupt_enable_register[5:0]};
  // One means high priority for every slot
  assign prio_all = {ext_priority_reg_b[6:0], ext_priority_reg_a,
                     base_priority_reg[5:0]};
  // Spare flag (bit 6) deliberately feeds nothing
  assign global_irq_gate = interrupt_enable_register[`CIC_EN_GATE_BIT];
  // Pending flags exist regardless of enables; only requests are gated
  assign req_all = pend_all & mask_all & {NUM_SLOTS{global_irq_gate}};

  cic_arbiter #(
    .N(NUM_SLOTS),
    .SW(SLOT_W)
  ) u_arb (
    .req(req_all),
    .prio(prio_all),
    .found(arb_found),
    .slot(arb_slot),
    .level(arb_level)
  );

  // Detect stage: winner registered every clock, costing one cycle
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      win_found <= 1'b0;
      win_slot <= {SLOT_W{1'b0}};
      win_level <= 1'b0;
    end else begin
      win_found <= arb_found;
      win_slot <= arb_slot;
      win_level <= arb_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Call sequencer

  // High may interrupt low only; equal level waits for the return
  assign eligible = win_found &&
    (win_level ? !in_service[1] : (in_service == 2'b00));
  // Taken only at an instruction boundary, not in the slot after return,
  // and not during the entry pulse, before in-service has caught up
  assign take = (state == ST_IDLE) && eligible && cpu_boundary &&
    !isr_enter && !reti_hold && !cpu_reti;
  assign next_vector = slot_vector(win_slot);

  // Four-cycle call then entry pulse; the commit is not revoked mid-call
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      call_cnt <= {`CIC_CNT_W{1'b0}};
      call_level <= 1'b0;
      lcall_active <= 1'b0;
      irq_vector <= 16'h0000;
      isr_enter <= 1'b0;
      isr_slot <= {SLOT_W{1'b0}};
    end else begin
      isr_enter <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take) begin
            state <= ST_CALL;
            call_cnt <= {`CIC_CNT_W{1'b0}};
            call_level <= win_level;
            lcall_active <= 1'b1;
            irq_vector <= next_vector;
            isr_slot <= win_slot;
          end
        end
        ST_CALL: begin
          if (call_cnt == CALL_LAST) begin
            state <= ST_IDLE;
            lcall_active <= 1'b0;
            isr_enter <= 1'b1;
          end else begin
            call_cnt <= call_cnt + 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          lcall_active <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // In-service tracking and return handling

  // A return closes the highest open level, then blocks one boundary so
  // exactly one instruction runs before any further call
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      in_service <= 2'b00;
      reti_hold <= 1'b0;
    end else begin
      if (isr_enter) begin
        if (call_level) begin
          in_service[1] <= 1'b1;
        end else begin
          in_service[0] <= 1'b1;
        end
      end else if (cpu_reti) begin
        if (in_service[1]) begin
          in_service[1] <= 1'b0;
        end else begin
          in_service[0] <= 1'b0;
        end
      end
      if (cpu_reti) begin
        reti_hold <= 1'b1;
      end else if (cpu_boundary) begin
        reti_hold <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  // Registered read data, valid the cycle after sfr_rd; unmapped reads zero
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `CIC_ADDR_EN: sfr_rdata <= interrupt_enable_register;
        `CIC_ADDR_PRIO: sfr_rdata <= base_priority_reg | `CIC_PRIO_READ_ONES;
        `CIC_ADDR_EIE_A: sfr_rdata <= ext_enable_reg_a;
        `CIC_ADDR_EIE_B: sfr_rdata <= ext_enable_reg_b;
        `CIC_ADDR_EIP_A: sfr_rdata <= ext_priority_reg_a;
        `CIC_ADDR_EIP_B: sfr_rdata <= ext_priority_reg_b;
        `CIC_ADDR_TCTL: sfr_rdata <= {4'h0, ext_pending[1], edge_select[1],
                                      ext_pending[0], edge_select[0]};
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end

endmodule

// ===== tb/cic_props.sv
// Checker: concurrent properties on the interrupt controller ports
module cic_props #(
  parameter SLOT_W = 5
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  // Call sequence
  input wire lcall_active,
  input wire [15:0] irq_vector,
  input wire isr_enter,
  input wire [SLOT_W-1:0] isr_slot,
  input wire [1:0] in_service
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [7:0] enable_m;
  ////////////////////////////////////////////////////////////////////////
  // Shadow of the enable register, so gating and reads can be judged
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      enable_m <= 8'h00;
    end else if (sfr_wr && sfr_addr == 8'hA8) begin
      enable_m <= sfr_wdata;
    end
  end
  // Four call cycles, then the entry pulse
  sequence call_s;
    lcall_active [*4] ##1 (!lcall_active && isr_enter);
  endsequence
  call_len_a: assert property ($rose(lcall_active) |-> call_s)
    else $error("call sequence length wrong");
  enter_pulse_a: assert property (isr_enter |=> !isr_enter && in_service != 2'h0)
    else $error("entry pulse or service level wrong");
  vec_map_a: assert property (lcall_active |->
    irq_vector == 16'h0003 + {8'h00, isr_slot, 3'h0})
    else $error("vector does not match slot");
  no_slot19_a: assert property (lcall_active |-> isr_slot != 5'h13)
    else $error("reserved slot called");
  gate_off_a: assert property (!enable_m[7] [*3] |=> !$rose(lcall_active))
    else $error("call taken with gate closed");
  high_hold_a: assert property (in_service[1] |=> !$rose(lcall_active))
    else $error("high routine preempted");
  enable_read_a: assert property (sfr_rd && sfr_addr == 8'hA8 |=>
    sfr_rdata == $past(enable_m))
    else $error("enable register read wrong");
  prio_read_a: assert property (sfr_rd && sfr_addr == 8'hB8 |=>
    sfr_rdata[7:6] == 2'h3)
    else $error("priority unused bits wrong");
endmodule

// ===== tb/cic_core_model.sv
// Core sequencer model: instruction boundaries and returns
module cic_core_model (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Commands from the bench, call state from the block
  input wire do_reti,
  input wire slow,
  input wire lcall_active,
  // Sequencer outputs
  output logic cpu_boundary,
  output logic cpu_reti
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cnt;
  logic want;
  // Commands taken on the rising edge to stay clear of the bench's edge
  always @(posedge clk) begin
    want <= do_reti;
  end
  // Outputs move on the falling edge; no instruction ends during a call
  always @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 2'h0;
      cpu_boundary <= 1'b0;
      cpu_reti <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      cpu_reti <= want;
      cpu_boundary <= !want && !lcall_active && (!slow || cnt == 2'h0);
    end
  end
endmodule

// ===== tb/test_cic_top.sv
// Bench: register tasks and interrupt scenarios for the controller
module test_cic_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic pin0_n = 1'b1;
  logic pin1_n = 1'b1;
  logic [20:0] src = 21'h000000;
  logic do_reti = 1'b0;
  logic slow = 1'b0;
  wire bnd, reti, lca, ent;
  wire [7:0] rdata;
  wire [15:0] vec;
  wire [4:0] slot;
  wire [1:0] insv;
  int n_fail = 0;
  int comparisons = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  cic_top dut (.clk(clk), .rstn(rstn), .sfr_addr(addr), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
    .external_irq_zero_pin_n(pin0_n), .external_irq_one_pin_n(pin1_n),
    .src_pending(src), .cpu_boundary(bnd), .cpu_reti(reti),
    .lcall_active(lca), .irq_vector(vec), .isr_enter(ent),
    .isr_slot(slot), .in_service(insv));
  cic_core_model core (.clk(clk), .rstn(rstn), .do_reti(do_reti),
    .slow(slow), .lcall_active(lca), .cpu_boundary(bnd), .cpu_reti(reti));
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_r(input logic [7:0] a, d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_r(input logic [7:0] a, exp);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    chk("sfr read", {8'h00, exp}, {8'h00, rdata});
  endtask
  // Waits a bounded time for the entry pulse, then checks the call
  task automatic call(input logic [4:0] s);
    for (int i = 0; i < 40 && ent !== 1'b1; i++) @(negedge clk);
    chk("entry", 16'h0001, {15'h0000, ent});
    chk("vector", 16'h0003 + {8'h00, s, 3'h0}, vec);
    chk("slot", {11'h000, s}, {11'h000, slot});
  endtask
  task automatic quiet;
    for (int i = 0; i < 20 && lca === 1'b0; i++) @(negedge clk);
    chk("no call", 16'h0000, {15'h0000, lca});
  endtask
  task automatic ret;
    @(negedge clk);
    do_reti = 1'b1;
    @(negedge clk);
    do_reti = 1'b0;
  endtask
  // Hang guard, well above the length of the sequence below
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    rd_r(8'hA8, 8'h00);
    rd_r(8'hB8, 8'hC0);
    rd_r(8'hF7, 8'h00);
    rd_r(8'h33, 8'h00);
    wr_r(8'hA8, 8'h41);
    rd_r(8'hA8, 8'h41);
    // Edge sense: flag latches with the gate shut, call once opened
    wr_r(8'h88, 8'h01);
    pin0_n = 1'b0;
    quiet;
    rd_r(8'h88, 8'h03);
    pin0_n = 1'b1;
    wr_r(8'hA8, 8'h81);
    call(5'h00);
    rd_r(8'h88, 8'h01);
    ret;
    wr_r(8'h88, 8'h03);
    call(5'h00);
    ret;
    // Level sense on input one, held low across one return
    wr_r(8'hA8, 8'h84);
    wr_r(8'h88, 8'h00);
    pin1_n = 1'b0;
    rd_r(8'h88, 8'h08);
    call(5'h02);
    ret;
    call(5'h02);
    pin1_n = 1'b1;
    rd_r(8'h88, 8'h00);
    ret;
    quiet;
    // Edge sense on input one: the fall sets the flag, entry clears it
    wr_r(8'h88, 8'h04);
    pin1_n = 1'b0;
    call(5'h02);
    pin1_n = 1'b1;
    rd_r(8'h88, 8'h04);
    ret;
    // Slow core: order among equal levels, then preemption
    slow = 1'b1;
    wr_r(8'hA8, 8'h80);
    wr_r(8'hE6, 8'h80);
    wr_r(8'hE7, 8'h12);
    src = 21'h04A000;
    call(5'h0D);
    src = 21'h048000;
    quiet;
    ret;
    call(5'h0F);
    wr_r(8'hF7, 8'h10);
    call(5'h12);
    @(negedge clk);
    chk("in service", 16'h0003, {14'h0000, insv});
    src = 21'h008000;
    ret;
    src = 21'h000000;
    ret;
    src = 21'h042000;
    call(5'h12);
    src = 21'h002000;
    ret;
    call(5'h0D);
    src = 21'h000000;
    ret;
    quiet;
    stop_test;
  end
endmodule
bind cic_top cic_props #(.SLOT_W(SLOT_W)) u_props (.clk(clk), .rstn(rstn),
  .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .lcall_active(lcall_active), .irq_vector(irq_vector),
  .isr_enter(isr_enter), .isr_slot(isr_slot), .in_service(in_service));
